// [design/emb_defines.svh]
// Constants of the external memory bus port
`ifndef EMB_DEFINES_SVH
`define EMB_DEFINES_SVH
`define EMB_CYCLE_PERIODS   6
`define EMB_ALE_PHASE       0
`define EMB_ADDR_PHASE      1
`define EMB_STROBE_PHASE    2
`define EMB_STROBE_END      4
`define EMB_INT_CODE_TOP    16'h1FFF
`define EMB_PORT_RESET      8'hFF
`define EMB_RESET_HOLD_CYC  24
`endif

// [design/emb_pkg.sv]
// Types of the external memory bus port
package emb_pkg;
	typedef enum logic [1:0] {
		EMB_IDLE,
		EMB_FETCH,
		EMB_DREAD,
		EMB_DWRITE
	} emb_kind_t;
endpackage

// [design/emb_bus_port.sv]
// External memory bus port: multiplexed address/data, strobes, download strap
//
// Behaviour
// - code fetch drives address high byte on port
// - data access drives middle byte, page on low port first
// - low port multiplexes address then data
// - general I/O low port is open drain
// - bus cycles drive ones actively
// - general I/O high port ones pulled weakly
// - latch strobe captures the low address byte, in fetches only
// - latch strobe every six periods in external fetches only
// - program strobe every six periods for external fetches
// - program strobe high for internal execution
// - program strobe low at reset enters download
// - select high: low 8K fetched internally
// - select low: all fetches external
// - write strobe latches low port data
// - read strobe lets memory drive port
`include "emb_defines.svh"
module emb_bus_port
	import emb_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        clk_en,
	input  wire logic        external_fetch_select,
	input  wire logic        fetch_req,
	input  wire logic [15:0] fetch_addr,
	input  wire logic        data_req,
	input  wire logic        data_write,
	input  wire logic [23:0] data_addr,
	input  wire logic [7:0]  data_wdata,
	input  wire logic [7:0]  low_latch,
	input  wire logic [7:0]  high_latch,
	output logic             req_ready,
	output logic             fetch_internal,
	output logic             rdata_valid,
	output logic [7:0]       rdata,
	output logic             serial_download,
	output logic             address_latch_strobe,
	output logic             program_store_strobe_out,
	output logic             program_store_strobe_oe,
	input  wire logic        program_store_strobe_in,
	output logic             data_store_strobe,
	output logic             data_load_strobe,
	input  wire logic [7:0]  low_bus_port_in,
	output logic [7:0]       low_bus_port_out,
	output logic [7:0]       low_bus_port_oe,
	output logic [7:0]       high_address_port_out,
	output logic [7:0]       high_address_port_oe,
	output logic [7:0]       high_address_port_pull
);
	logic [2:0]  phase;
	emb_kind_t   kind;
	logic [23:0] addr;
	logic [7:0]  wdata;
	logic        strap_taken;
	logic [2:0]  next_phase;
	emb_kind_t   next_kind;
	logic        at_start;
	logic        last_phase;
	logic        fetch_is_int;
	logic        bus_active;
	logic        strobe_win;
	emb_kind_t   start_kind;
	logic        take_data;
	logic        take_fetch;
	logic        capture_read;

	// Pin decodes
	logic        fetch_cycle;
	logic        write_cycle;
	logic        read_cycle;
	logic        addr_window;
	logic        page_window;
	logic        next_ale;
	logic        next_program_store_strobe;
	logic        next_wr;
	logic        next_rd;
	logic [7:0]  next_low_out;
	logic [7:0]  next_low_oe;
	logic [7:0]  next_high_out;
	logic [7:0]  next_high_oe;
	logic [7:0]  next_high_pull;

	// Phase inside an inclusive window
	function automatic logic emb_phase_in(input logic [2:0] p, input logic [2:0] lo,
		input logic [2:0] hi);
		emb_phase_in = (p >= lo) && (p <= hi);
	endfunction

	function automatic logic emb_internal(input logic sel, input logic [15:0] a);
		emb_internal = sel && (a <= `EMB_INT_CODE_TOP);
	endfunction

	assign last_phase   = (phase == 3'(`EMB_CYCLE_PERIODS - 1));
	assign at_start     = (kind == EMB_IDLE) || last_phase;
	// Internal range only with select high; otherwise and above it, external
	assign fetch_is_int = emb_internal(external_fetch_select, fetch_addr);
	assign req_ready    = at_start;
	assign fetch_internal = fetch_is_int;
	assign bus_active   = (kind != EMB_IDLE);
	assign strobe_win   = bus_active
		&& emb_phase_in(phase, 3'(`EMB_STROBE_PHASE), 3'(`EMB_STROBE_END));
	assign next_phase   = last_phase ? 3'h0 : phase + 3'h1;

	// Data requests first; internal fetches make no bus cycle
	assign start_kind = data_req ? (data_write ? EMB_DWRITE : EMB_DREAD)
		: (fetch_req && !fetch_is_int) ? EMB_FETCH
		: EMB_IDLE;
	assign take_data  = at_start && data_req;
	assign take_fetch = at_start && (start_kind == EMB_FETCH);

	always_comb
	begin
		next_kind = kind;
		case (kind)
			EMB_IDLE:
				next_kind = start_kind;
			default:
				if (last_phase)
					next_kind = start_kind;
		endcase
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			phase <= 3'h0;
			kind  <= EMB_IDLE;
		end
		else if (clk_en)
		begin
			// Every cycle opens at phase zero, so each lasts six periods
			phase <= at_start ? 3'h0 : next_phase;
			kind  <= next_kind;
		end
	end

	// Address and write data held for the whole cycle
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			addr  <= 24'h000000;
			wdata <= 8'h00;
		end
		else if (clk_en)
		begin
			if (take_data)
			begin
				addr  <= data_addr;
				wdata <= data_wdata;
			end
			else if (take_fetch)
				addr <= {8'h00, fetch_addr};
		end
	end

	// Strap sampled on first enabled edge after release
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			strap_taken     <= 1'b0;
			serial_download <= 1'b0;
		end
		else if (clk_en && !strap_taken)
		begin
			strap_taken     <= 1'b1;
			serial_download <= !program_store_strobe_in;
		end
	end

	// Read data captured at the end of phase four, one period before the load or program strobe rises
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			rdata       <= 8'h00;
			rdata_valid <= 1'b0;
		end
		else if (clk_en)
		begin
			rdata_valid <= 1'b0;
			if (capture_read)
			begin
				rdata       <= low_bus_port_in;
				rdata_valid <= 1'b1;
			end
		end
	end

	assign fetch_cycle  = (kind == EMB_FETCH);
	assign write_cycle  = (kind == EMB_DWRITE);
	assign read_cycle   = (kind == EMB_DREAD);
	assign addr_window  = bus_active && (phase < 3'(`EMB_STROBE_PHASE));
	assign page_window  = bus_active && !fetch_cycle
		&& (phase == 3'(`EMB_ALE_PHASE));
	assign capture_read = (fetch_cycle || read_cycle)
		&& (phase == 3'(`EMB_STROBE_END));

	// Latch pulse in phase zero of a fetch, address launched alongside
	assign next_ale  = fetch_cycle && (phase == 3'(`EMB_ALE_PHASE));
	// Program strobe stays high for internal code and data cycles
	assign next_program_store_strobe = !(fetch_cycle && strobe_win);
	assign next_wr   = !(write_cycle && strobe_win);
	assign next_rd   = !(read_cycle && strobe_win);

	// Low port: page byte, low address, then write data or released
	assign next_low_out = !bus_active ? 8'h00
		: page_window ? addr[23:16]
		: addr_window ? addr[7:0]
		: wdata;
	// Bus cycles drive ones hard; idle pins with latch one float
	assign next_low_oe  = !bus_active ? ~low_latch
		: (addr_window || write_cycle) ? 8'hFF
		: 8'h00;

	// High port: address byte in bus cycles, weak pull-up where latch is one
	assign next_high_out  = bus_active ? addr[15:8] : 8'h00;
	assign next_high_oe   = bus_active ? 8'hFF : ~high_latch;
	assign next_high_pull = bus_active ? 8'h00 : high_latch;

	// Address latch strobe
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			address_latch_strobe <= 1'b0;
		else if (clk_en)
			address_latch_strobe <= next_ale;
	end

	// Program store strobe
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			program_store_strobe_out <= 1'b1;
		else if (clk_en)
			program_store_strobe_out <= next_program_store_strobe;
	end

	// Data store strobe
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			data_store_strobe <= 1'b1;
		else if (clk_en)
			data_store_strobe <= next_wr;
	end

	// Data load strobe
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			data_load_strobe <= 1'b1;
		else if (clk_en)
			data_load_strobe <= next_rd;
	end

	// Low port output latch
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			low_bus_port_out <= `EMB_PORT_RESET;
		else if (clk_en)
			low_bus_port_out <= next_low_out;
	end

	// Low port drive enable
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			low_bus_port_oe <= 8'h00;
		else if (clk_en)
			low_bus_port_oe <= next_low_oe;
	end

	// High port output latch
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			high_address_port_out <= `EMB_PORT_RESET;
		else if (clk_en)
			high_address_port_out <= next_high_out;
	end

	// High port drive enable
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			high_address_port_oe <= 8'h00;
		else if (clk_en)
			high_address_port_oe <= next_high_oe;
	end

	// High port weak pull-up request
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			high_address_port_pull <= 8'h00;
		else if (clk_en)
			high_address_port_pull <= next_high_pull;
	end

	assign program_store_strobe_oe = strap_taken;
endmodule

// [bench/emb_bus_port_chk.sv]
// Bus port protocol checker
module emb_bus_port_chk(
	input wire logic       mclk,
	input wire logic       reset,
	input wire logic       address_latch_strobe,
	input wire logic       program_store_strobe_out,
	input wire logic       data_store_strobe,
	input wire logic       data_load_strobe,
	input wire logic [7:0] low_bus_port_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	property p_ale; address_latch_strobe |=> !address_latch_strobe; endproperty
	a_ale: assert property (p_ale) else $error("ale");
	property p_psn; address_latch_strobe |-> ##2 !program_store_strobe_out [*3]; endproperty
	a_psn: assert property (p_psn) else $error("program_store_strobe");
	property p_wal; !data_store_strobe |-> !address_latch_strobe; endproperty
	a_wal: assert property (p_wal) else $error("wr ale");
	property p_rwx; data_store_strobe || data_load_strobe; endproperty
	a_rwx: assert property (p_rwx) else $error("rd wr");
	property p_psd; !data_load_strobe |-> program_store_strobe_out; endproperty
	a_psd: assert property (p_psd) else $error("rd program_store_strobe");
	property p_wdr; !data_store_strobe |-> low_bus_port_oe == 8'hFF; endproperty
	a_wdr: assert property (p_wdr) else $error("wr oe");
	property p_rfl; !data_load_strobe |-> low_bus_port_oe == 8'h00; endproperty
	a_rfl: assert property (p_rfl) else $error("rd oe");
	property p_aoe; address_latch_strobe |-> low_bus_port_oe == 8'hFF; endproperty
	a_aoe: assert property (p_aoe) else $error("addr oe");
endmodule
bind emb_bus_port emb_bus_port_chk emb_bus_port_chk_i(.*);

// [bench/emb_ext_mem.sv]
// External memory behind an address latch
module emb_ext_mem(
	input wire logic       mclk,
	input wire logic       address_latch_strobe,
	input wire logic       program_store_strobe_out,
	input wire logic       data_store_strobe,
	input wire logic [7:0] low_bus_port_in,
	input wire logic [7:0] high_address_port_out,
	output logic [7:0]     q,
	output logic [7:0]     wq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] lat;
	always_ff @(posedge mclk) if (address_latch_strobe) lat <= low_bus_port_in;
	always_ff @(posedge mclk) if (!data_store_strobe) wq <= low_bus_port_in;
	assign q = program_store_strobe_out ? ~high_address_port_out : lat ^ high_address_port_out;
endmodule

// [bench/external_memory_bus_port_test.sv]
// Self-checking bench of the bus port
module external_memory_bus_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, reset, clk_en, external_fetch_select, fetch_req, data_req, data_write, strap, ie;
	logic req_ready, fetch_internal, rdata_valid, serial_download, address_latch_strobe;
	logic program_store_strobe_out, program_store_strobe_oe, program_store_strobe_in;
	logic data_store_strobe, data_load_strobe;
	logic [15:0] fetch_addr;
	logic [23:0] data_addr, a;
	logic [7:0] data_wdata, low_latch, high_latch, rdata, low_bus_port_in, low_bus_port_out, q, wq;
	logic [7:0] low_bus_port_oe, high_address_port_out, high_address_port_oe, high_address_port_pull;
	int err_count, n_checks, i, t, k;
	logic [7:0] exp_q[$];
	emb_bus_port emb_bus_port_i(.*);
	emb_ext_mem emb_ext_mem_i(.*);
	// Memory drives only under its strobes, else the bus shows a changing value
	assign low_bus_port_in = low_bus_port_oe & low_bus_port_out | ~low_bus_port_oe
		& (program_store_strobe_out & data_load_strobe ? ~low_bus_port_out : q);
	assign program_store_strobe_in = program_store_strobe_oe ? program_store_strobe_out : strap;
	always #12.5 mclk = ~mclk;
	task chk(input logic [7:0] g, e);
		n_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %0t got %h", $time, g);
		end
	endtask
	task give_verdict(input int late);
		err_count += late;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial #20us give_verdict(1);
	initial
	begin
		{mclk, reset, clk_en, strap, external_fetch_select, fetch_req, data_req, data_write} = 8'h78;
		{fetch_addr, data_addr, data_wdata, err_count, n_checks} = 0;
		void'($urandom(32'hA8DE));
		{low_latch, high_latch} = 16'($urandom);
		repeat (8) @(negedge mclk);
		reset = 0;
		@(negedge mclk);
		chk(low_bus_port_oe, ~low_latch);
		chk(high_address_port_pull, high_latch);
		chk(high_address_port_oe, ~high_latch);
		chk(8'({program_store_strobe_out, serial_download, req_ready}), 8'h05);
		for (i = 0; i < 24; i++)
		begin
			k = i % 3;
			a = 24'(i[3] ? $urandom % 8192 : $urandom);
			external_fetch_select = 1'($urandom);
			{fetch_addr, data_addr, data_wdata} = {a[15:0], a, ~a[7:0]};
			{fetch_req, data_req, data_write} = {k == 0, k > 0, k == 2};
			#1 ie = k == 0 && external_fetch_select && fetch_addr <= 16'h1FFF;
			chk(8'(fetch_internal), 8'(external_fetch_select && fetch_addr <= 16'h1FFF));
			if (!ie)
				exp_q.push_back(k == 2 ? ~a[7:0] : k ? ~a[15:8] : a[7:0] ^ a[15:8]);
			@(negedge mclk);
			{fetch_req, data_req} = 0;
			clk_en = (i != 4);
			repeat (3) @(negedge mclk);
			clk_en = 1;
			for (t = 0; t < 9 && !rdata_valid; t++)
				@(negedge mclk);
			chk(8'(rdata_valid), 8'(k < 2 && !ie));
			if (!ie)
				chk(k == 2 ? wq : rdata, exp_q.pop_front());
			$display("op %0d kind %0d done", i, k);
		end
		strap = 0;
		reset = 1;
		repeat (24) @(negedge mclk);
		reset = 0;
		@(negedge mclk);
		chk(8'(serial_download), 8'h01);
		give_verdict(0);
	end
endmodule
